//--- shared/nsd_pkg.sv
package nsd_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam logic [11:0] SWAP_MASK = 12'hfc0;
	localparam logic [11:0] SWAP_CODE = 12'h380;
	localparam logic [11:0] DIRLD_MASK = 12'hff8;
	localparam logic [11:0] DIRLD_CODE = 12'h000;
	localparam int DEST_BIT = 5;
	localparam logic [2:0] PORT_FIRST = 3'h5;
	localparam logic [2:0] PORT_SECOND = 3'h6;
	localparam logic [2:0] PORT_THIRD = 3'h7;
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam int NUM_PORTS = 3;

	typedef enum logic [1:0] {
		NSD_IDLE,
		NSD_SWAP,
		NSD_DIRLD,
		NSD_OTHER
	} nsd_kind_type;

	typedef struct packed {
		logic [7:0] acc;
		logic acc_we;
		logic [4:0] file_addr;
		logic [7:0] file_wdata;
		logic file_we;
		logic [7:0] dir_first;
		logic [7:0] second_port_direction;
		logic [7:0] dir_third;
		logic illegal;
		nsd_kind_type kind;
	} nsd_state_type;

	typedef struct packed {
		logic [7:0] value;
		logic load;
	} nsd_dir_in_type;
endpackage

//--- design/nsd_dir_reg.sv
`timescale 1ns/100ps
`default_nettype none
module nsd_dir_reg
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire nsd_pkg::nsd_dir_in_type din,
	output logic [7:0] dir
);
	logic [7:0] dir_r;
	logic [7:0] dir_nxt;

	always_comb
	begin
		dir_nxt = dir_r;
		if (din.load)
			dir_nxt = din.value;
	end

	// Set on reset so pins start as inputs with drivers off
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			dir_r <= nsd_pkg::DIR_RESET;
		else
			dir_r <= dir_nxt;
	end

	assign dir = dir_r;
endmodule
`default_nettype wire

//--- design/nsd_exec.sv
// Notes on behaviour
// - Swap result exchanges operand's two nibbles.
// - Destination clear: result to accumulator only.
// - Destination set: result written one cycle later at file_addr, the source register only while instr[4:0] is held.
// - Direction load accepts only selectors 5-7.
// - Direction load copies accumulator into selected register.
`timescale 1ns/100ps
`default_nettype none
module nsd_exec
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [11:0] instr,
	input wire logic [7:0] file_rdata,
	output logic [4:0] file_addr,
	output logic [7:0] file_wdata,
	output logic file_we,
	output logic [7:0] acc,
	output logic acc_we,
	output logic [7:0] dir_first,
	output logic [7:0] second_port_direction,
	output logic [7:0] dir_third,
	output logic illegal,
	output logic swap_done,
	output logic dirld_done
);
	nsd_pkg::nsd_state_type st_r;
	nsd_pkg::nsd_state_type st_nxt;
	nsd_pkg::nsd_dir_in_type din [nsd_pkg::NUM_PORTS];
	logic [7:0] dir_q [nsd_pkg::NUM_PORTS];
	logic is_swap;
	logic is_dirld;
	logic [7:0] swapped;
	logic [2:0] sel;

	assign is_swap = instr_valid && ((instr & nsd_pkg::SWAP_MASK) == nsd_pkg::SWAP_CODE);
	assign is_dirld = instr_valid && ((instr & nsd_pkg::DIRLD_MASK) == nsd_pkg::DIRLD_CODE);
	assign swapped = {file_rdata[3:0], file_rdata[7:4]};
	assign sel = instr[2:0];

	// Operand address is combinational from the word so the file read lands in the same cycle
	assign file_addr = instr[4:0];

	always_comb
	begin
		for (int i = 0; i < nsd_pkg::NUM_PORTS; i++)
		begin
			din[i].value = st_r.acc;
			din[i].load = is_dirld && (sel == 3'(i + 5));
		end
	end

	genvar g;
	generate
		for (g = 0; g < nsd_pkg::NUM_PORTS; g++)
		begin : g_dir
			nsd_dir_reg nsd_dir_reg_i
			(
				.clk(clk),
				.sys_rst(sys_rst),
				.din(din[g]),
				.dir(dir_q[g])
			);
		end
	endgenerate

	// Swap and direction load retire in their own cycle; illegal, swap_done and dirld_done flag them on the next edge, other words raise no flag
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.acc_we = 1'b0;
		st_nxt.file_we = 1'b0;
		st_nxt.illegal = 1'b0;
		st_nxt.kind = nsd_pkg::NSD_IDLE;
		st_nxt.file_addr = instr[4:0];
		st_nxt.dir_first = dir_q[0];
		st_nxt.second_port_direction = dir_q[1];
		st_nxt.dir_third = dir_q[2];
		if (is_swap)
		begin
			st_nxt.kind = nsd_pkg::NSD_SWAP;
			if (instr[nsd_pkg::DEST_BIT])
			begin
				st_nxt.file_wdata = swapped;
				st_nxt.file_we = 1'b1;
			end
			else
			begin
				st_nxt.acc = swapped;
				st_nxt.acc_we = 1'b1;
			end
		end
		else if (is_dirld)
		begin
			st_nxt.kind = nsd_pkg::NSD_DIRLD;
			// Selectors 0-4 leave every direction register alone
			if (sel < nsd_pkg::PORT_FIRST)
				st_nxt.illegal = 1'b1;
		end
		else if (instr_valid)
			st_nxt.kind = nsd_pkg::NSD_OTHER;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_r <= '0;
			st_r.acc <= nsd_pkg::ACC_RESET;
			st_r.dir_first <= nsd_pkg::DIR_RESET;
			st_r.second_port_direction <= nsd_pkg::DIR_RESET;
			st_r.dir_third <= nsd_pkg::DIR_RESET;
			st_r.kind <= nsd_pkg::NSD_IDLE;
		end
		else
			st_r <= st_nxt;
	end

	assign file_wdata = st_r.file_wdata;
	assign file_we = st_r.file_we;
	assign acc = st_r.acc;
	assign acc_we = st_r.acc_we;
	// Mirrors lag the internal direction registers by one cycle
	assign dir_first = st_r.dir_first;
	assign second_port_direction = st_r.second_port_direction;
	assign dir_third = st_r.dir_third;
	assign illegal = st_r.illegal;
	assign swap_done = (st_r.kind == nsd_pkg::NSD_SWAP);
	assign dirld_done = (st_r.kind == nsd_pkg::NSD_DIRLD);
endmodule
`default_nettype wire

//--- bench/nsd_exec_sva.sv
`timescale 1ns/100ps
`default_nettype none
module nsd_chk
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire logic [11:0] instr,
	input wire logic [7:0] file_rdata,
	input wire logic [7:0] file_wdata,
	input wire logic file_we,
	input wire logic [7:0] acc,
	input wire logic acc_we,
	input wire logic [7:0] second_port_direction,
	input wire logic illegal
);
	wire logic sw = instr_valid && instr[11:6] == 6'h0e;
	wire logic dl = instr_valid && instr[11:3] == 9'h000;
	wire logic bad = dl && instr[2:0] < 3'h5;
	wire logic [7:0] sx = {file_rdata[3:0], file_rdata[7:4]};
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_swap_file: assert property (sw && instr[5] |=> file_we && file_wdata == $past(sx))
		else $error("bad swap to file");
	a_swap_acc: assert property (sw && !instr[5] |=> acc_we && !file_we && acc == $past(sx))
		else $error("bad swap to acc");
	a_dir_copy: assert property (dl && instr[2:0] == 3'h6 |-> ##2 second_port_direction == $past(acc, 2))
		else $error("bad dir load");
	a_bad_sel: assert property (dl |=> illegal == $past(bad))
		else $error("bad selector flag");
	a_acc_hold: assert property (!acc_we |-> $stable(acc))
		else $error("acc changed");
	a_one_word: assert property (file_we |-> $past(sw))
		else $error("stray write");
endmodule
bind nsd_exec nsd_chk nsd_chk_i (.*);
`default_nettype wire

//--- bench/test_nsd_exec.sv
`timescale 1ns/100ps
`default_nettype none
module test_nsd_exec;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic instr_valid = 1'h0;
	logic [11:0] instr = 12'h0;
	logic [7:0] file_rdata = 8'h0;
	logic [4:0] file_addr;
	logic [7:0] file_wdata, acc, dir_first, second_port_direction, dir_third;
	logic file_we, acc_we, illegal, swap_done, dirld_done;
	int err_total = 0;
	int num_checks = 0;
	nsd_exec nsd_exec_i (.*);
	initial forever #2 clk = ~clk;
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic issue(logic [11:0] w, logic [7:0] r);
		@(negedge clk);
		instr = w;
		file_rdata = r;
		instr_valid = 1'h1;
		@(negedge clk);
		instr_valid = 1'h0;
		file_rdata = ~r;
	endtask
	task automatic t_reset;
		chk("acc", acc, nsd_pkg::ACC_RESET);
		chk("dir_first", dir_first, nsd_pkg::DIR_RESET);
		chk("dir_second", second_port_direction, nsd_pkg::DIR_RESET);
		chk("dir_third", dir_third, nsd_pkg::DIR_RESET);
		$display("reset done");
	endtask
	task automatic t_swap;
		issue(12'h385, 8'ha5);
		chk("acc", acc, 8'h5a);
		chk("acc_we", {7'h0, acc_we}, 8'h01);
		chk("we", {7'h0, file_we}, 8'h00);
		chk("swap_done", {7'h0, swap_done}, 8'h01);
		issue(12'h3a5, 8'h3c);
		chk("wdata", file_wdata, 8'hc3);
		chk("we", {7'h0, file_we}, 8'h01);
		chk("acc_we", {7'h0, acc_we}, 8'h00);
		chk("acc", acc, 8'h5a);
		$display("swap done");
	endtask
	task automatic t_dir;
		for (int p = 5; p < 8; p++)
		begin
			issue(12'h385, {p[3:0], 4'h9});
			issue({9'h0, p[2:0]}, 8'h0);
			chk("illegal", {7'h0, illegal}, 8'h00);
			chk("dirld_done", {7'h0, dirld_done}, 8'h01);
			@(negedge clk);
			if (p == 5)
				chk("dir_first", dir_first, {4'h9, p[3:0]});
			else if (p == 6)
				chk("dir_second", second_port_direction, {4'h9, p[3:0]});
			else
				chk("dir_third", dir_third, {4'h9, p[3:0]});
		end
		issue(12'h004, 8'h0);
		chk("illegal", {7'h0, illegal}, 8'h01);
		@(negedge clk);
		chk("dir", dir_first, 8'h95);
		$display("dir done");
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		sys_rst = 1'h0;
		t_reset;
		t_swap;
		t_dir;
		stop_test;
	end
	initial
	begin
		#2000;
		err_total++;
		stop_test;
	end
endmodule
`default_nettype wire
